// *** ccts_regs.svh ***
// register offsets, field positions and timing counts of the scheduler
`ifndef CCTS_REGS_SVH
`define CCTS_REGS_SVH
`define CCTS_A_CTRL0     8'h00
`define CCTS_A_CTRL1     8'h04
`define CCTS_A_CMD       8'h08
`define CCTS_A_STAT      8'h0c
`define CCTS_A_EID       8'h10
`define CCTS_A_EDATA_LO  8'h14
`define CCTS_A_EDATA_HI  8'h18
`define CCTS_A_EPERIOD   8'h1c
`define CCTS_A_PORT      8'h20
`define CCTS_A_SEL       8'h24
`define CCTS_A_LOAD      8'h28
`define CCTS_B_RUN       31
`define CCTS_B_SEQ       30
`define CCTS_B_NOECHO    16
`define CCTS_B_STB       6
`define CCTS_B_EN        7
`define CCTS_MAX_ENTRIES 5'h10
`define CCTS_TICK_NS     1000000
`define CCTS_CLK_NS      100
`define CCTS_RESP_OKAY   2'b00
`define CCTS_RESP_SLVERR 2'b10
`define CCTS_RESP_DECERR 2'b11
`endif

// *** ccts_pkg.sv ***
// types shared by the cyclic transmit scheduler
package ccts_pkg;
    typedef struct packed {
        logic [28:0] id;
        logic [63:0] data;
        logic [31:0] period;
    } ccts_entry_t;
    typedef enum logic [1:0] {
        CCTS_IDLE = 2'b00,
        CCTS_SEND = 2'b01,
        CCTS_WAIT = 2'b10
    } ccts_tx_state_t;
endpackage : ccts_pkg

// *** ccts_tx_if.sv ***
// frame hand-off between channel scheduler and transmit arbiter
`timescale 1ns/1ps
interface ccts_tx_if;
    import ccts_pkg::*;
    logic        req;
    logic        ack;
    ccts_entry_t frame;
    logic        no_echo;
    modport sched (output req, output frame, output no_echo, input ack);
    modport arb   (input req, input frame, input no_echo, output ack);
endinterface : ccts_tx_if

// *** ccts_chan.sv ***
// one channel: entry table, control word and due-time scheduler
`timescale 1ns/1ps
`include "ccts_regs.svh"
module ccts_chan #(
    parameter int NENT = 16
) (
    input  wire logic                 ref_clk_i,
    input  wire logic                 rst_b_i,
    input  wire logic                 tick_i,
    input  wire logic                 wr_ent_i,
    input  wire logic [3:0]           wr_idx_i,
    input  wire ccts_pkg::ccts_entry_t wr_ent_val_i,
    input  wire logic                 load_i,
    input  wire logic [4:0]           load_cnt_i,
    input  wire logic                 ctrl_wr_i,
    input  wire logic [31:0]          ctrl_val_i,
    input  wire logic [3:0]           rd_idx_i,
    output ccts_pkg::ccts_entry_t     rd_ent_o,
    output logic [4:0]                count_o,
    output logic [31:0]               ctrl_o,
    ccts_tx_if.sched                  tx
);
    import ccts_pkg::*;
    typedef struct packed {
        logic [4:0]       count;
        logic [31:0]      ctrl;
        logic [3:0]       cur;
        logic [31:0]      seq_age;
        logic [NENT-1:0]  pend;
        ccts_tx_state_t   st;
        logic [3:0]       sel;
    } ccts_cst_t;
    ccts_cst_t   s_ff, nxt_s;
    ccts_entry_t tab   [NENT];
    ccts_entry_t stage [NENT];
    logic [31:0] age   [NENT];
    logic [NENT-1:0] live;
    logic [NENT-1:0] due;
    logic [3:0]      first_due;
    logic            any_due;
    logic [3:0]      nxt_live;
    logic            any_live;

    // staging array written by host, copied whole on load
    always_ff @(posedge ref_clk_i) begin
        if (wr_ent_i) begin
            stage[wr_idx_i] <= wr_ent_val_i;
        end
    end

    // per-entry table, live mask and elapsed-time counters
    for (genvar g = 0; g < NENT; g++) begin : g_ent
        assign live[g] = (5'(g) < s_ff.count)
                         && !s_ff.ctrl[g];
        assign due[g]  = live[g] && (age[g] >= tab[g].period);
        always_ff @(posedge ref_clk_i) begin
            if (load_i) begin
                tab[g] <= stage[g];
            end
        end
        always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
            if (!rst_b_i) begin
                age[g] <= '0;
            end else if (load_i || (tx.ack && s_ff.sel == 4'(g))) begin
                age[g] <= '0; // period restarts at own send
            end else if (tick_i && age[g] != '1) begin
                age[g] <= age[g] + 32'h1;
            end
        end
    end

    // lowest due entry wins in parallel mode
    always_comb begin
        first_due = '0;
        any_due   = 1'b0;
        for (int i = NENT - 1; i >= 0; i--) begin
            if (due[i]) begin
                first_due = 4'(i);
                any_due   = 1'b1;
            end
        end
    end

    // next unlocked entry after the current one in list order
    always_comb begin
        nxt_live = '0;
        any_live = 1'b0;
        for (int k = NENT; k >= 1; k--) begin
            if (live[4'(s_ff.cur + 4'(k))]) begin
                nxt_live = 4'(s_ff.cur + 4'(k));
                any_live = 1'b1;
            end
        end
    end

    // scheduling state machine
    always_comb begin
        nxt_s = s_ff;
        if (ctrl_wr_i) begin
            nxt_s.ctrl = ctrl_val_i;
        end
        if (load_i) begin
            nxt_s.count   = load_cnt_i;
            nxt_s.cur     = 4'hf;
            nxt_s.seq_age = '0;
        end else if (tick_i && s_ff.seq_age != '1) begin
            nxt_s.seq_age = s_ff.seq_age + 32'h1;
        end
        case (s_ff.st)
            CCTS_IDLE: begin
                if (s_ff.ctrl[`CCTS_B_RUN] && !load_i) begin
                    if (s_ff.ctrl[`CCTS_B_SEQ]) begin
                        if (any_live && s_ff.seq_age
                                >= tab[nxt_live].period) begin
                            nxt_s.sel = nxt_live;
                            nxt_s.st  = CCTS_SEND;
                        end
                    end else if (any_due) begin
                        nxt_s.sel = first_due;
                        nxt_s.st  = CCTS_SEND;
                    end
                end
            end
            CCTS_SEND: begin
                if (tx.ack) begin
                    nxt_s.cur     = s_ff.sel;
                    nxt_s.seq_age = '0;
                    nxt_s.st      = CCTS_IDLE;
                end
            end
            default: begin
                nxt_s.st = CCTS_IDLE;
            end
        endcase
    end

    // state register
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            s_ff <= '{count: '0, ctrl: '0, cur: 4'hf, seq_age: '0,
                      pend: '0, st: CCTS_IDLE, sel: '0};
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign tx.req     = (s_ff.st == CCTS_SEND);
    assign tx.frame   = tab[s_ff.sel];
    assign tx.no_echo = s_ff.ctrl[`CCTS_B_NOECHO];
    assign rd_ent_o   = tab[rd_idx_i];
    assign count_o    = s_ff.count;
    assign ctrl_o     = s_ff.ctrl;

    // a locked entry is never offered
    property p_lock_hold;
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        tx.req |-> !s_ff.ctrl[s_ff.sel] && (5'(s_ff.sel) < s_ff.count);
    endproperty
    a_lock_hold: assert property (p_lock_hold)
        else $error("locked or undefined entry offered");

    // no new request while stopped
    property p_stop;
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        $rose(tx.req) |-> $past(s_ff.ctrl[`CCTS_B_RUN]);
    endproperty
    a_stop: assert property (p_stop)
        else $error("frame offered while stopped");

    // parallel: frame is offered only after its period
    property p_par_due;
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        $rose(tx.req) && !$past(s_ff.ctrl[`CCTS_B_SEQ]) |->
            $past(any_due) && s_ff.sel == $past(first_due);
    endproperty
    a_par_due: assert property (p_par_due)
        else $error("parallel frame offered early");

    // sequential: gap from previous send at least the period
    property p_seq_due;
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        $rose(tx.req) && $past(s_ff.ctrl[`CCTS_B_SEQ]) |->
            $past(s_ff.seq_age) >= tab[s_ff.sel].period;
    endproperty
    a_seq_due: assert property (p_seq_due)
        else $error("sequential frame offered early");

    // empty table never sends
    property p_empty;
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        s_ff.count == 5'h0 |-> ##1 !$rose(tx.req);
    endproperty
    a_empty: assert property (p_empty)
        else $error("frame sent from empty table");

    // load replaces the count next cycle
    property p_load;
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        load_i |=> s_ff.count == $past(load_cnt_i);
    endproperty
    a_load: assert property (p_load)
        else $error("entry count not replaced by load");

    // request holds until acknowledged
    property p_req_hold;
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        tx.req && !tx.ack |=> tx.req;
    endproperty
    a_req_hold: assert property (p_req_hold)
        else $error("request dropped before ack");
endmodule : ccts_chan

// *** ccts_top.sv ***
// cyclic CAN transmit scheduler, two channels, AXI4-Lite registers
// Functional notes
// - each channel holds up to 16 id/data/period entries
// - a load replaces the whole table
// - entry count 0 to 16; larger count refused
// - count zero leaves no entry to send; table contents stay readable
// - host reads back entries and count
// - run bit starts and stops sending
// - select bit picks ordered or parallel mode
// - suppress bit stops transmit echo
// - inhibit bits 0 to 15 lock entries
// - control word applied as one setting
// - channel 0 or 1; others refused
// - port write drives standby and activate levels
// - high-speed variant ignores port write, answers OKAY
// - parallel: entry due one period after own send
// - ordered: list order, period from previous send
// - port bit 0x40 drives standby
// - port bit 0x80 drives activate
`timescale 1ns/1ps
`include "ccts_regs.svh"
module ccts_top #(
    parameter int NCH     = 2,
    parameter int TICK_NS = `CCTS_TICK_NS
) (
    input  wire logic        ref_clk_i,
    input  wire logic        rst_b_i,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        hs_variant_i,
    output logic             tx_valid_o,
    input  wire logic        tx_ready_i,
    output logic             tx_chan_o,
    output logic [28:0]      tx_id_o,
    output logic [63:0]      tx_data_o,
    output logic             tx_no_echo_o,
    output logic [NCH-1:0]   transceiver_standby_out_o,
    output logic [NCH-1:0]   transceiver_activate_out_o
);
    import ccts_pkg::*;
    localparam int TICK_CYC = TICK_NS / `CCTS_CLK_NS;

    typedef struct packed {
        logic        aw_ok, w_ok, awr, wr, bv, arr, rv;
        logic [7:0]  awa;
        logic [31:0] wd;
        logic [1:0]  bresp, rresp;
        logic [31:0] rdata;
        logic        ch;
        logic [3:0]  idx;
        ccts_entry_t ent;
        logic [NCH-1:0] stb, en;
        logic [31:0] tcnt;
        logic        tick;
        logic        busy, txv, txc, noe;
        logic [28:0] tid;
        logic [63:0] tdat;
        logic        rr;
        logic        hs_q1, hs_q2, hs_q3, hs;
    } ccts_tst_t;
    ccts_tst_t s_ff, nxt_s;

    logic [NCH-1:0]  ctrl_wr, load, wr_ent;
    ccts_entry_t     rd_ent [NCH];
    logic [4:0]      cnt    [NCH];
    logic [31:0]     ctrl   [NCH];
    logic [NCH-1:0]  req, ack;
    ccts_entry_t     frm    [NCH];
    logic [NCH-1:0]  noe;
    logic            wdo;
    logic [7:0]      wa;
    logic            wbad;
    logic            gnt;

    // one channel instance per CAN channel
    for (genvar c = 0; c < NCH; c++) begin : g_ch
        ccts_tx_if txi ();
        assign req[c]      = txi.req;
        assign frm[c]      = txi.frame;
        assign noe[c]      = txi.no_echo;
        assign txi.ack     = ack[c];
        ccts_chan #(.NENT(16)) u_chan (
            .ref_clk_i    (ref_clk_i),
            .rst_b_i      (rst_b_i),
            .tick_i       (s_ff.tick),
            .wr_ent_i     (wr_ent[c]),
            .wr_idx_i     (s_ff.idx),
            .wr_ent_val_i (nxt_s.ent),
            .load_i       (load[c]),
            .load_cnt_i   (s_ff.wd[4:0]),
            .ctrl_wr_i    (ctrl_wr[c]),
            .ctrl_val_i   (s_ff.wd),
            .rd_idx_i     (s_ff.idx),
            .rd_ent_o     (rd_ent[c]),
            .count_o      (cnt[c]),
            .ctrl_o       (ctrl[c]),
            .tx           (txi.sched)
        );
        assign ctrl_wr[c] = wdo && wa == ((c == 0) ? `CCTS_A_CTRL0
                                                 : `CCTS_A_CTRL1);
        assign load[c]    = wdo && wa == `CCTS_A_LOAD && !wbad
                            && s_ff.ch == 1'(c);
        assign wr_ent[c]  = wdo && wa == `CCTS_A_EPERIOD
                            && s_ff.ch == 1'(c);
        // grant goes to the channel the arbiter latched
        assign ack[c]     = s_ff.txv && tx_ready_i && s_ff.txc == 1'(c);
    end

    // write fires once both address and data are held
    assign wdo  = s_ff.aw_ok && s_ff.w_ok && !s_ff.bv;
    assign wa   = s_ff.awa;
    // illegal count or channel refused with slave error
    assign wbad = (wa == `CCTS_A_LOAD
                   && s_ff.wd[31:0] > 32'(`CCTS_MAX_ENTRIES))
                  || (wa == `CCTS_A_SEL && s_ff.wd[31:1] != '0);
    assign gnt  = !s_ff.busy && (req != '0);

    always_comb begin
        nxt_s = s_ff;
        // pin input synchroniser, three stages
        nxt_s.hs_q1 = hs_variant_i;
        nxt_s.hs_q2 = s_ff.hs_q1;
        nxt_s.hs_q3 = s_ff.hs_q2;
        if (s_ff.hs_q2 == s_ff.hs_q3) begin
            nxt_s.hs = s_ff.hs_q3;
        end
        // millisecond tick from clock divider
        nxt_s.tick = 1'b0;
        if (s_ff.tcnt >= 32'(TICK_CYC - 1)) begin
            nxt_s.tcnt = '0;
            nxt_s.tick = 1'b1;
        end else begin
            nxt_s.tcnt = s_ff.tcnt + 32'h1;
        end
        // write address and data accepted in either order
        nxt_s.awr = !s_ff.aw_ok;
        nxt_s.wr  = !s_ff.w_ok;
        if (s_axi_awvalid && s_ff.awr) begin
            nxt_s.aw_ok = 1'b1;
            nxt_s.awa   = s_axi_awaddr;
            nxt_s.awr   = 1'b0;
        end
        if (s_axi_wvalid && s_ff.wr) begin
            nxt_s.w_ok = 1'b1;
            nxt_s.wd   = s_axi_wdata;
            nxt_s.wr   = 1'b0;
        end
        if (wdo) begin
            nxt_s.bv    = 1'b1;
            nxt_s.bresp = wbad ? `CCTS_RESP_SLVERR : `CCTS_RESP_OKAY;
            case (wa)
                `CCTS_A_CTRL0, `CCTS_A_CTRL1, `CCTS_A_LOAD: ;
                `CCTS_A_SEL:      if (!wbad) nxt_s.ch = s_ff.wd[0];
                `CCTS_A_CMD:      nxt_s.idx = s_ff.wd[3:0];
                `CCTS_A_EID:      nxt_s.ent.id = s_ff.wd[28:0];
                `CCTS_A_EDATA_LO: nxt_s.ent.data[31:0] = s_ff.wd;
                `CCTS_A_EDATA_HI: nxt_s.ent.data[63:32] = s_ff.wd;
                `CCTS_A_EPERIOD:  nxt_s.ent.period = s_ff.wd;
                `CCTS_A_PORT: begin
                    // ignored but answered OKAY on high-speed parts
                    if (!s_ff.hs) begin
                        nxt_s.stb[s_ff.ch] = s_ff.wd[`CCTS_B_STB];
                        nxt_s.en[s_ff.ch]  = s_ff.wd[`CCTS_B_EN];
                    end
                end
                default: nxt_s.bresp = `CCTS_RESP_DECERR;
            endcase
        end
        if (s_ff.bv && s_axi_bready) begin
            nxt_s.bv   = 1'b0;
            nxt_s.aw_ok = 1'b0;
            nxt_s.w_ok  = 1'b0;
            nxt_s.awr   = 1'b1;
            nxt_s.wr    = 1'b1;
        end
        // read: one cycle after address, held until rready
        nxt_s.arr = !s_ff.rv;
        if (s_axi_arvalid && s_ff.arr) begin
            nxt_s.arr   = 1'b0;
            nxt_s.rv    = 1'b1;
            nxt_s.rresp = `CCTS_RESP_OKAY;
            case (s_axi_araddr)
                `CCTS_A_CTRL0:    nxt_s.rdata = ctrl[0];
                `CCTS_A_CTRL1:    nxt_s.rdata = ctrl[1];
                `CCTS_A_CMD:      nxt_s.rdata = {28'h0, s_ff.idx};
                `CCTS_A_STAT:     nxt_s.rdata = {27'h0, cnt[s_ff.ch]};
                `CCTS_A_EID:      nxt_s.rdata = {3'h0, rd_ent[s_ff.ch].id};
                `CCTS_A_EDATA_LO: nxt_s.rdata = rd_ent[s_ff.ch].data[31:0];
                `CCTS_A_EDATA_HI: nxt_s.rdata = rd_ent[s_ff.ch].data[63:32];
                `CCTS_A_EPERIOD:  nxt_s.rdata = rd_ent[s_ff.ch].period;
                `CCTS_A_PORT:     nxt_s.rdata = {24'h0, s_ff.en[s_ff.ch],
                                                 s_ff.stb[s_ff.ch], 6'h0};
                `CCTS_A_SEL:      nxt_s.rdata = {31'h0, s_ff.ch};
                `CCTS_A_LOAD:     nxt_s.rdata = {27'h0, cnt[s_ff.ch]};
                default: begin
                    nxt_s.rdata = '0;
                    nxt_s.rresp = `CCTS_RESP_DECERR;
                end
            endcase
        end
        if (s_ff.rv && s_axi_rready) begin
            nxt_s.rv = 1'b0;
        end
        // pick of a channel frame for the controller; on a tie the channel served last wins again
        if (gnt) begin
            nxt_s.busy = 1'b1;
            nxt_s.txv  = 1'b1;
            nxt_s.txc  = (req[1] && (!req[0] || !s_ff.rr)) ? 1'b1 : 1'b0;
            nxt_s.tid  = frm[nxt_s.txc].id;
            nxt_s.tdat = frm[nxt_s.txc].data;
            nxt_s.noe  = noe[nxt_s.txc];
        end
        if (s_ff.txv && tx_ready_i) begin
            nxt_s.txv  = 1'b0;
            nxt_s.rr   = ~s_ff.txc;
        end
        if (s_ff.busy && !s_ff.txv) begin
            nxt_s.busy = 1'b0; // one idle cycle lets scheduler drop req
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            s_ff     <= '0;
            s_ff.awr <= 1'b1;
            s_ff.wr  <= 1'b1;
            s_ff.arr <= 1'b1;
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign s_axi_awready = s_ff.awr;
    assign s_axi_wready  = s_ff.wr;
    assign s_axi_bvalid  = s_ff.bv;
    assign s_axi_bresp   = s_ff.bresp;
    assign s_axi_arready = s_ff.arr;
    assign s_axi_rvalid  = s_ff.rv;
    assign s_axi_rdata   = s_ff.rdata;
    assign s_axi_rresp   = s_ff.rresp;
    assign tx_valid_o    = s_ff.txv;
    assign tx_chan_o     = s_ff.txc;
    assign tx_id_o       = s_ff.tid;
    assign tx_data_o     = s_ff.tdat;
    assign tx_no_echo_o  = s_ff.noe;
    assign transceiver_standby_out_o  = s_ff.stb;
    assign transceiver_activate_out_o = s_ff.en;

    // oversized entry count is refused
    property p_bad_count;
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        wdo && wa == `CCTS_A_LOAD && s_ff.wd > 32'(`CCTS_MAX_ENTRIES)
            |-> load == '0 ##1 s_axi_bresp == `CCTS_RESP_SLVERR;
    endproperty
    a_bad_count: assert property (p_bad_count)
        else $error("illegal entry count accepted");
endmodule : ccts_top

// *** ccts_can_model.sv ***
// behavioural CAN controller taking frames from the scheduler
`timescale 1ns/1ps
module ccts_can_model (
    input  wire logic        ref_clk_i,
    input  wire logic        rst_b_i,
    input  wire logic        slow_i,
    input  wire logic        tx_valid_i,
    input  wire logic        tx_chan_i,
    input  wire logic [28:0] tx_id_i,
    input  wire logic        tx_no_echo_i,
    output logic             tx_ready_o
);
    int          cnt [16];
    int          tot;
    int          dly;
    logic [28:0] seq [$];
    logic        ne;
    logic        ch;
    // forget what was seen before a new window
    function automatic void clr();
        foreach (cnt[i]) cnt[i] = 0;
        tot = 0;
        seq.delete();
    endfunction : clr
    // slow mode keeps valid waiting, as a busy bus would
    always @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            tx_ready_o <= 1'b0;
            dly = 0;
        end else if (tx_valid_i && tx_ready_o) begin
            cnt[tx_id_i[3:0]]++;
            tot++;
            seq.push_back(tx_id_i);
            ne = tx_no_echo_i;
            ch = tx_chan_i;
            tx_ready_o <= 1'b0;
            dly = 0;
        end else if (tx_valid_i) begin
            tx_ready_o <= (dly >= (slow_i ? 4 : 0));
            dly++;
        end
    end
endmodule : ccts_can_model

// *** ccts_top_tb.sv ***
// self-checking bench for the cyclic transmit scheduler
`timescale 1ns/1ps
`include "ccts_regs.svh"
module ccts_top_tb;
    localparam logic [1:0]  OK  = `CCTS_RESP_OKAY;
    localparam logic [31:0] RUN = 32'h8000_0000;
    localparam logic [31:0] SEQ = 32'h4000_0000;
    logic        ref_clk_i, rst_b_i, hs, slow;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic        awv, awr, wv, wr, bv, br, arv, arr, rv, rr, tv, tr, tch, tne;
    logic [1:0]  bresp, rresp, stb, act;
    logic [28:0] tid;
    logic [63:0] tdat;
    int          fails, tests_run;

    ccts_top #(.TICK_NS(1000)) DUT (
        .ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wr),
        .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br),
        .s_axi_araddr(araddr), .s_axi_arvalid(arv), .s_axi_arready(arr),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rv),
        .s_axi_rready(rr), .hs_variant_i(hs), .tx_valid_o(tv),
        .tx_ready_i(tr), .tx_chan_o(tch), .tx_id_o(tid), .tx_data_o(tdat),
        .tx_no_echo_o(tne), .transceiver_standby_out_o(stb),
        .transceiver_activate_out_o(act));
    ccts_can_model model (
        .ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .slow_i(slow),
        .tx_valid_i(tv), .tx_chan_i(tch), .tx_id_i(tid),
        .tx_no_echo_i(tne), .tx_ready_o(tr));

    // clock at 10 MHz
    initial begin
        ref_clk_i = 1'b0;
        forever #50 ref_clk_i = ~ref_clk_i;
    end

    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : stop_test

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk

    task automatic rng(input int v, input int lo, input int hi);
        chk(32'(v >= lo && v <= hi), 32'h1);
    endtask : rng

    task automatic cyc(input int k);
        repeat (k) @(posedge ref_clk_i);
    endtask : cyc

    // aw and w offered together, each dropped once taken
    task automatic axw(input logic [7:0] a, input logic [31:0] d,
                       input logic [1:0] er);
        int n;
        n = 0;
        @(posedge ref_clk_i);
        awaddr <= a;
        wdata <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        br <= 1'b1;
        do begin
            @(posedge ref_clk_i);
            n++;
            if (awr && awv) awv <= 1'b0;
            if (wr && wv) wv <= 1'b0;
        end while (!(bv && br) && n < 60);
        br <= 1'b0;
        if (n >= 60) fails++;
        chk(32'(bresp), 32'(er));
    endtask : axw

    task automatic axr(input logic [7:0] a, input logic [31:0] exp,
                       input logic [1:0] er);
        int n;
        n = 0;
        @(posedge ref_clk_i);
        araddr <= a;
        arv <= 1'b1;
        rr <= 1'b1;
        do begin
            @(posedge ref_clk_i);
            n++;
            if (arr && arv) arv <= 1'b0;
        end while (!(rv && rr) && n < 60);
        rr <= 1'b0;
        if (n >= 60) fails++;
        chk(32'(rresp), 32'(er));
        if (er == OK) chk(rdata, exp);
    endtask : axr

    // one entry into the staging slot of the selected channel
    task automatic ent(input logic [3:0] i, input logic [28:0] id,
                       input logic [31:0] p);
        axw(`CCTS_A_CMD, {28'h0, i}, OK);
        axw(`CCTS_A_EID, {3'h0, id}, OK);
        axw(`CCTS_A_EDATA_LO, {3'h0, id}, OK);
        axw(`CCTS_A_EDATA_HI, ~{3'h0, id}, OK);
        axw(`CCTS_A_EPERIOD, p, OK);
    endtask : ent

    // run for k cycles with control word c, then stop
    task automatic run(input logic [7:0] a, input logic [31:0] c,
                       input int k);
        model.clr();
        axw(a, c, OK);
        cyc(k);
        axw(a, 32'h0, OK);
        cyc(20);
    endtask : run

    task automatic t_refuse;
        axr(`CCTS_A_STAT, 32'h0, OK);
        chk({28'h0, stb, act}, 32'h0);
        axw(8'h40, 32'h1, `CCTS_RESP_DECERR);
        axr(8'h40, 32'h0, `CCTS_RESP_DECERR);
        axw(`CCTS_A_SEL, 32'h2, `CCTS_RESP_SLVERR);
        axw(`CCTS_A_LOAD, 32'h11, `CCTS_RESP_SLVERR);
        axr(`CCTS_A_STAT, 32'h0, OK);
    endtask : t_refuse

    task automatic t_load;
        axw(`CCTS_A_SEL, 32'h0, OK);
        ent(4'h0, 29'h1, 32'h2);
        ent(4'h1, 29'h2, 32'h5);
        ent(4'h2, 29'h3, 32'h3);
        axw(`CCTS_A_LOAD, 32'h10, OK);
        axr(`CCTS_A_STAT, 32'h10, OK);
        axw(`CCTS_A_LOAD, 32'h3, OK);
        axw(`CCTS_A_LOAD, 32'h2, OK);
        axr(`CCTS_A_STAT, 32'h2, OK);
        axw(`CCTS_A_CMD, 32'h1, OK);
        axr(`CCTS_A_EID, 32'h2, OK);
        axr(`CCTS_A_EPERIOD, 32'h5, OK);
    endtask : t_load

    // periods 2 and 5 ticks of 10 cycles each, slow far side
    task automatic t_par;
        slow <= 1'b1;
        run(`CCTS_A_CTRL0, RUN | 32'h0001_0000, 400);
        rng(model.cnt[1], 17, 22);
        rng(model.cnt[2], 6, 10);
        chk(32'(model.cnt[3]), 32'h0);
        chk({31'h0, model.ne}, 32'h1);
        chk({31'h0, model.ch}, 32'h0);
        model.clr();
        cyc(200);
        chk(32'(model.tot), 32'h0);
    endtask : t_par

    task automatic t_seq;
        slow <= 1'b0;
        run(`CCTS_A_CTRL0, RUN | SEQ, 400);
        rng(model.seq[0], 1, 2);
        for (int k = 1; k < 4; k++) begin
            chk({3'h0, model.seq[k]}, 32'h3 - model.seq[k-1]);
        end
        chk({31'h0, model.ne}, 32'h0);
        run(`CCTS_A_CTRL0, RUN | SEQ | 32'h1, 300);
        chk(32'(model.cnt[1]), 32'h0);
        rng(model.cnt[2], 4, 7);
        run(`CCTS_A_CTRL0, RUN | 32'h3, 300);
        chk(32'(model.tot), 32'h0);
    endtask : t_seq

    task automatic t_ch1;
        axw(`CCTS_A_SEL, 32'h1, OK);
        run(`CCTS_A_CTRL1, RUN, 200);
        chk(32'(model.tot), 32'h0);
        ent(4'h0, 29'h3, 32'h2);
        axw(`CCTS_A_LOAD, 32'h1, OK);
        run(`CCTS_A_CTRL1, RUN, 200);
        rng(model.cnt[3], 8, 12);
        chk({31'h0, model.ch}, 32'h1);
        chk(tdat[31:0], 32'h3);
        chk(tdat[63:32], ~32'h3);
        axw(`CCTS_A_LOAD, 32'h0, OK);
        axr(`CCTS_A_STAT, 32'h0, OK);
        run(`CCTS_A_CTRL1, RUN, 200);
        chk(32'(model.tot), 32'h0);
    endtask : t_ch1

    // channel one still selected; levels follow bits 6 and 7
    task automatic t_port;
        axw(`CCTS_A_PORT, 32'h40, OK);
        cyc(2);
        chk({28'h0, stb, act}, 32'h8);
        axw(`CCTS_A_PORT, 32'h80, OK);
        cyc(2);
        chk({28'h0, stb, act}, 32'h2);
        hs <= 1'b1;
        cyc(5);
        axw(`CCTS_A_PORT, 32'hc0, OK);
        cyc(2);
        chk({28'h0, stb, act}, 32'h2);
    endtask : t_port

    // main sequence
    initial begin
        rst_b_i = 1'b0;
        hs = 1'b0;
        slow = 1'b0;
        awaddr = 8'h0;
        araddr = 8'h0;
        wdata = 32'h0;
        {awv, wv, br, arv, rr} = 5'h0;
        fails = 0;
        tests_run = 0;
        cyc(5);
        rst_b_i <= 1'b1;
        t_refuse();
        t_load();
        t_par();
        t_seq();
        t_ch1();
        t_port();
        stop_test();
    end

    // watchdog, far beyond the few thousand cycles the tests need
    initial begin
        #2000000;
        fails++;
        stop_test();
    end
endmodule : ccts_top_tb
